// [core/twmo_chan.sv]
`timescale 1ns/1ps
// ==========================================================
// One compare channel: buffered compare value, output state, pin mux
module twmo_chan
    import twmo_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic [15:0] cmp_wr_data_i,
    input  wire logic        cmp_wr_i,
    input  wire logic [1:0]  compare_action_field_i,
    input  wire logic        force_match_strobe_i,
    input  wire logic        pin_direction_bit_i,
    input  wire logic        port_value_i,
    input  wire logic        tick_i,
    input  wire logic        is_pwm_i,
    input  wire logic        is_dual_i,
    input  wire logic        buffered_i,
    input  wire logic        load_i,
    input  wire logic        at_bottom_i,
    input  wire logic        up_i,
    input  wire logic        hold_i,
    input  wire logic        block_i,
    input  wire logic [15:0] counter_i,
    output logic [15:0]      compare_value_o,
    output logic             compare_match_o,
    output logic             compare_output_state_o,
    output logic             pin_out_o,
    output logic             pin_oe_o
);

    logic [15:0] buf_reg;
    logic [15:0] cmp_reg;
    logic        ocs_reg;
    logic        ocs_next;
    logic        match;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            buf_reg <= TWMO_BOTTOM;
        end else if (cmp_wr_i) begin
            buf_reg <= cmp_wr_data_i;
        end
    end

    // Unbuffered modes write straight through; PWM modes reload at update point
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmp_reg <= TWMO_BOTTOM;
        end else if (!buffered_i && cmp_wr_i) begin
            cmp_reg <= cmp_wr_data_i;
        end else if (buffered_i && load_i) begin
            cmp_reg <= buf_reg;
        end
    end

    assign match = tick_i && !hold_i && !block_i && (counter_i == cmp_reg);

    // Action read live each match, so a new field acts from the next match on
    always_comb begin
        ocs_next = ocs_reg;
        if (!is_pwm_i) begin
            if ((match || force_match_strobe_i) && !hold_i) begin
                case (compare_action_field_i)
                    TWMO_ACT_TOGGLE: ocs_next = ~ocs_reg;
                    TWMO_ACT_CLEAR:  ocs_next = 1'b0;
                    TWMO_ACT_SET:    ocs_next = 1'b1;
                    default:         ocs_next = ocs_reg;
                endcase
            end
        end else if (compare_action_field_i[1]) begin
            if (is_dual_i) begin
                if (match) begin
                    ocs_next = up_i ^ compare_action_field_i[0];
                end
            end else if (match) begin
                ocs_next = compare_action_field_i[0];
            end else if (tick_i && at_bottom_i) begin
                ocs_next = ~compare_action_field_i[0];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ocs_reg <= 1'b0;
        end else begin
            ocs_reg <= ocs_next;
        end
    end

    assign compare_value_o        = cmp_reg;
    assign compare_match_o        = match;
    assign compare_output_state_o = ocs_reg;
    // Pin mux: override source only, direction stays with the direction bit
    assign pin_out_o = (compare_action_field_i != TWMO_ACT_NONE) ? ocs_reg : port_value_i;
    assign pin_oe_o  = pin_direction_bit_i;

endmodule : twmo_chan

// [core/twmo_top.sv]
`timescale 1ns/1ps
// ==========================================================
// Timer waveform mode decoder, counter and compare output units
module twmo_top
    import twmo_pkg::*;
#(
    parameter int NCH = 3
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              timer_tick_i,
    input  wire logic [3:0]        waveform_mode_field_i,
    input  wire logic [15:0]       counter_wr_data_i,
    input  wire logic              counter_wr_i,
    input  wire logic [15:0]       capture_value_i,
    input  wire logic              overflow_clear_i,
    input  wire logic [15:0]       cmp_wr_data_i,
    input  wire logic [NCH-1:0]    cmp_wr_i,
    input  wire logic [2*NCH-1:0]  compare_action_field_i,
    input  wire logic [NCH-1:0]    force_match_strobe_i,
    input  wire logic [NCH-1:0]    pin_direction_bit_i,
    input  wire logic [NCH-1:0]    port_value_i,
    output logic [15:0]            counter_value_o,
    output logic                   overflow_flag_o,
    output logic [NCH-1:0]         compare_match_o,
    output logic [NCH-1:0]         compare_output_state_o,
    output logic [NCH-1:0]         pin_out_o,
    output logic [NCH-1:0]         pin_oe_o,
    output logic                   capture_uses_top_o,
    output logic                   legacy_clear_on_match_bit_o,
    output logic [1:0]             legacy_pulse_mode_bits_o
);

    // ==========================================================
    // Mode decode
    twmo_kind_type    kind;
    twmo_top_src_type top_src;
    logic [15:0]      fixed_top;
    logic [15:0]      top_val;
    logic [15:0]      cnt_reg;
    logic [15:0]      cnt_next;
    logic             down_reg;
    logic             down_next;
    logic             ovf_reg;
    logic             blk_reg;
    logic             at_top;
    logic             at_bot;
    logic             ovf_set;
    logic             load_pt;
    logic             is_pwm;
    logic             is_dual;
    logic             hold;
    logic [15:0]      cmp_a;
    logic [16*NCH-1:0] cmp_all;

    // Decode only from the mode field; action fields never enter here
    always_comb begin
        kind      = TWMO_K_RSVD;
        top_src   = TWMO_T_MAX;
        fixed_top = TWMO_MAX;
        case (waveform_mode_field_i)
            TWMO_M_NORMAL:  kind = TWMO_K_NORMAL;
            TWMO_M_PC8: begin
                kind = TWMO_K_PHASE; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP8;
            end
            TWMO_M_PC9: begin
                kind = TWMO_K_PHASE; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP9;
            end
            TWMO_M_PC10: begin
                kind = TWMO_K_PHASE; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP10;
            end
            TWMO_M_CTC_A: begin
                kind = TWMO_K_CTC; top_src = TWMO_T_CMPA;
            end
            TWMO_M_FP8: begin
                kind = TWMO_K_FAST; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP8;
            end
            TWMO_M_FP9: begin
                kind = TWMO_K_FAST; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP9;
            end
            TWMO_M_FP10: begin
                kind = TWMO_K_FAST; top_src = TWMO_T_FIXED; fixed_top = TWMO_TOP10;
            end
            TWMO_M_PFC_CAP: begin
                kind = TWMO_K_PFC; top_src = TWMO_T_CAP;
            end
            TWMO_M_PFC_A: begin
                kind = TWMO_K_PFC; top_src = TWMO_T_CMPA;
            end
            TWMO_M_PC_CAP: begin
                kind = TWMO_K_PHASE; top_src = TWMO_T_CAP;
            end
            TWMO_M_PC_A: begin
                kind = TWMO_K_PHASE; top_src = TWMO_T_CMPA;
            end
            TWMO_M_CTC_CAP: begin
                kind = TWMO_K_CTC; top_src = TWMO_T_CAP;
            end
            TWMO_M_FP_CAP: begin
                kind = TWMO_K_FAST; top_src = TWMO_T_CAP;
            end
            TWMO_M_FP_A: begin
                kind = TWMO_K_FAST; top_src = TWMO_T_CMPA;
            end
            default: kind = TWMO_K_RSVD;
        endcase
    end

    always_comb begin
        case (top_src)
            TWMO_T_FIXED: top_val = fixed_top;
            TWMO_T_CAP:   top_val = capture_value_i;
            TWMO_T_CMPA:  top_val = cmp_a;
            default:      top_val = TWMO_MAX;
        endcase
    end

    assign is_pwm  = (kind == TWMO_K_FAST) || (kind == TWMO_K_PHASE) || (kind == TWMO_K_PFC);
    assign is_dual = (kind == TWMO_K_PHASE) || (kind == TWMO_K_PFC);
    assign hold    = (kind == TWMO_K_RSVD);
    assign at_top  = (cnt_reg == top_val);
    assign at_bot  = (cnt_reg == TWMO_BOTTOM);

    // Legacy names are simply views of the low mode bits, same place and meaning
    assign legacy_clear_on_match_bit_o = waveform_mode_field_i[2];
    assign legacy_pulse_mode_bits_o    = waveform_mode_field_i[1:0];
    // Input capture only loses its input when capture defines top; action fields absent
    assign capture_uses_top_o = (top_src == TWMO_T_CAP);

    // ==========================================================
    // Counter
    always_comb begin
        cnt_next  = cnt_reg;
        down_next = down_reg;
        case (kind)
            TWMO_K_NORMAL: cnt_next = cnt_reg + TWMO_ONE;
            TWMO_K_CTC, TWMO_K_FAST: begin
                // A top below the count runs on to max and wraps
                cnt_next = at_top ? TWMO_BOTTOM : cnt_reg + TWMO_ONE;
            end
            TWMO_K_PHASE, TWMO_K_PFC: begin
                if (down_reg) begin
                    if (cnt_reg == TWMO_ONE || at_bot) begin
                        down_next = 1'b0;
                    end
                    cnt_next = at_bot ? TWMO_ONE : cnt_reg - TWMO_ONE;
                end else if (at_top || cnt_reg > top_val) begin
                    down_next = 1'b1;
                    cnt_next  = cnt_reg - TWMO_ONE;
                end else begin
                    cnt_next = cnt_reg + TWMO_ONE;
                end
            end
            default: cnt_next = cnt_reg;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= TWMO_BOTTOM;
            down_reg <= 1'b0;
        end else if (counter_wr_i) begin
            cnt_reg <= counter_wr_data_i;
        end else if (timer_tick_i) begin
            cnt_reg  <= cnt_next;
            down_reg <= is_dual ? down_next : 1'b0;
        end
    end

    // A counter write masks compare matches for the next timer cycle
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            blk_reg <= 1'b0;
        end else if (counter_wr_i) begin
            blk_reg <= 1'b1;
        end else if (timer_tick_i) begin
            blk_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Overflow flag and compare reload points
    always_comb begin
        ovf_set = 1'b0;
        load_pt = 1'b0;
        if (timer_tick_i && !counter_wr_i) begin
            case (kind)
                TWMO_K_NORMAL, TWMO_K_CTC: ovf_set = (cnt_reg == TWMO_MAX);
                TWMO_K_FAST: begin
                    ovf_set = at_top;
                    load_pt = at_top;
                end
                TWMO_K_PHASE: begin
                    ovf_set = at_bot;
                    load_pt = at_top && !down_reg;
                end
                TWMO_K_PFC: begin
                    ovf_set = at_bot;
                    load_pt = at_bot;
                end
                default: ovf_set = 1'b0;
            endcase
        end
    end

    // Set beats a same-cycle clear so no wrap is lost
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ovf_reg <= 1'b0;
        end else if (ovf_set) begin
            ovf_reg <= 1'b1;
        end else if (overflow_clear_i) begin
            ovf_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Compare channels
    assign cmp_a = cmp_all[15:0];

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            twmo_chan u_chan (
                .clk_i                  (clk_i),
                .rst_n_i                (rst_n_i),
                .cmp_wr_data_i          (cmp_wr_data_i),
                .cmp_wr_i               (cmp_wr_i[gi]),
                .compare_action_field_i (compare_action_field_i[2*gi+1:2*gi]),
                .force_match_strobe_i   (force_match_strobe_i[gi]),
                .pin_direction_bit_i    (pin_direction_bit_i[gi]),
                .port_value_i           (port_value_i[gi]),
                .tick_i                 (timer_tick_i),
                .is_pwm_i               (is_pwm),
                .is_dual_i              (is_dual),
                .buffered_i             (is_pwm),
                .load_i                 (load_pt),
                .at_bottom_i            (at_top),
                .up_i                   (!down_reg),
                .hold_i                 (hold),
                .block_i                (blk_reg),
                .counter_i              (cnt_reg),
                .compare_value_o        (cmp_all[16*gi+15:16*gi]),
                .compare_match_o        (compare_match_o[gi]),
                .compare_output_state_o (compare_output_state_o[gi]),
                .pin_out_o              (pin_out_o[gi]),
                .pin_oe_o               (pin_oe_o[gi])
            );
        end
    endgenerate

    assign counter_value_o = cnt_reg;
    assign overflow_flag_o = ovf_reg;

endmodule : twmo_top

// [shared/twmo_pkg.sv]
// Functional notes
// - Reset clears every channel's internal compare output state to zero.
// - Nonzero action field makes compare output state replace the port output value.
// - Pin direction always follows the direction bit; state visible only when output.
// - Output state can be set up before the pin driver is enabled.
// - Action fields never touch the input capture logic.
// - Action zero leaves compare output state unchanged on match.
// - A written action field takes effect from the next compare match.
// - Force strobe in normal and CTC modes applies the configured action at once.
// - Counting sequence depends only on the mode field.
// - PWM modes pick polarity; non-PWM modes pick set, clear or toggle.
// - Mode field decode: normal, phase correct, CTC, fast, phase-frequency, 13 reserved.
// - Modes 1-3 use fixed 8/9/10-bit tops, load at top, overflow at bottom.
// - Mode bits 2..0 keep their legacy positions and meanings.
// - Mode 0 counts up, never clears on match, wraps from max to zero.
// - Mode 0 sets overflow as the counter becomes zero; counting never clears it.
// - Counter may be written at any time in mode 0 and is accepted.
// - CTC clears at compare A in mode 4, at capture value in mode 12.
// - Fast PWM modes 5-7 count to fixed top, then clear next cycle.
// - Fast PWM top is capture value in mode 14, compare A in mode 15.
package twmo_pkg;

    // ==========================================================
    // Widths and fixed values
    localparam int          TWMO_CW      = 16;
    localparam logic [15:0] TWMO_BOTTOM  = 16'h0000;
    localparam logic [15:0] TWMO_MAX     = 16'hffff;
    localparam logic [15:0] TWMO_TOP8    = 16'h00ff;
    localparam logic [15:0] TWMO_TOP9    = 16'h01ff;
    localparam logic [15:0] TWMO_TOP10   = 16'h03ff;
    localparam logic [15:0] TWMO_ONE     = 16'h0001;

    // ==========================================================
    // Action field codes
    localparam logic [1:0]  TWMO_ACT_NONE   = 2'h0;
    localparam logic [1:0]  TWMO_ACT_TOGGLE = 2'h1;
    localparam logic [1:0]  TWMO_ACT_CLEAR  = 2'h2;
    localparam logic [1:0]  TWMO_ACT_SET    = 2'h3;

    // ==========================================================
    // Mode field codes
    localparam logic [3:0]  TWMO_M_NORMAL  = 4'h0;
    localparam logic [3:0]  TWMO_M_PC8     = 4'h1;
    localparam logic [3:0]  TWMO_M_PC9     = 4'h2;
    localparam logic [3:0]  TWMO_M_PC10    = 4'h3;
    localparam logic [3:0]  TWMO_M_CTC_A   = 4'h4;
    localparam logic [3:0]  TWMO_M_FP8     = 4'h5;
    localparam logic [3:0]  TWMO_M_FP9     = 4'h6;
    localparam logic [3:0]  TWMO_M_FP10    = 4'h7;
    localparam logic [3:0]  TWMO_M_PFC_CAP = 4'h8;
    localparam logic [3:0]  TWMO_M_PFC_A   = 4'h9;
    localparam logic [3:0]  TWMO_M_PC_CAP  = 4'ha;
    localparam logic [3:0]  TWMO_M_PC_A    = 4'hb;
    localparam logic [3:0]  TWMO_M_CTC_CAP = 4'hc;
    localparam logic [3:0]  TWMO_M_RSVD    = 4'hd;
    localparam logic [3:0]  TWMO_M_FP_CAP  = 4'he;
    localparam logic [3:0]  TWMO_M_FP_A    = 4'hf;

    typedef enum logic [2:0] {
        TWMO_K_NORMAL,
        TWMO_K_CTC,
        TWMO_K_FAST,
        TWMO_K_PHASE,
        TWMO_K_PFC,
        TWMO_K_RSVD
    } twmo_kind_type;

    typedef enum logic [1:0] {
        TWMO_T_MAX,
        TWMO_T_FIXED,
        TWMO_T_CAP,
        TWMO_T_CMPA
    } twmo_top_src_type;

endpackage : twmo_pkg

// [verification/test_timer_waveform_mode_output.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module test_timer_waveform_mode_output;
    import twmo_pkg::*;
    localparam int NCH = 3;
    logic             clk_i, rst_n_i, timer_tick_i, counter_wr_i, overflow_clear_i;
    logic [3:0]       waveform_mode_field_i;
    logic [15:0]      counter_wr_data_i, capture_value_i, cmp_wr_data_i, counter_value_o;
    logic [NCH-1:0]   cmp_wr_i, force_match_strobe_i, pin_direction_bit_i, port_value_i;
    logic [2*NCH-1:0] compare_action_field_i;
    logic             overflow_flag_o, capture_uses_top_o, legacy_clear_on_match_bit_o;
    logic [NCH-1:0]   compare_match_o, compare_output_state_o, pin_out_o, pin_oe_o, pin_level;
    logic [1:0]       legacy_pulse_mode_bits_o;
    int               bad_count, cmp_count;
    logic             exp;
    logic [1:0]       acts [5] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h1};
    // Rows from index 8 on are dual-slope and start from reset so they count up
    logic [3:0]  tm [13] = '{4'h4, 4'hf, 4'hc, 4'he, 4'h0, 4'h5, 4'h6, 4'h7,
                             4'h1, 4'h2, 4'h3, 4'h8, 4'ha};
    logic [15:0] ts [13] = '{16'h0004, 16'h0004, 16'h0005, 16'h0005, 16'hfffe, 16'h00fe,
                             16'h01fe, 16'h03fe, 16'h00fe, 16'h01fe, 16'h03fe, 16'h0005,
                             16'h0005};
    logic [15:0] te [13] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                             16'h0000, 16'h0000, 16'h00fe, 16'h01fe, 16'h03fe, 16'h0005,
                             16'h0005};

    twmo_top #(.NCH(NCH)) twmo_top_inst (.*);
    twmo_pin_model #(.NCH(NCH)) twmo_pin_model_inst (.pin_out_i(pin_out_o),
        .pin_oe_i(pin_oe_o), .pin_level_o(pin_level));

    // ==========================================================
    // Helpers
    function automatic logic act_next(input logic [1:0] a, input logic s);
        return (a == 2'h0) ? s : (a == 2'h1) ? ~s : (a == 2'h3);
    endfunction : act_next
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask : step
    task automatic wr_cnt(input logic [15:0] v);
        counter_wr_data_i = v;
        counter_wr_i = 1'b1;
        step(1);
        counter_wr_i = 1'b0;
        step(1);
    endtask : wr_cnt
    task automatic pulse_force();
        force_match_strobe_i = 3'h1;
        step(1);
        force_match_strobe_i = 3'h0;
        step(1);
    endtask : pulse_force
    task automatic ticks(input int n);
        timer_tick_i = 1'b1;
        step(n);
        timer_tick_i = 1'b0;
        step(1);
    endtask : ticks
    task automatic do_reset();
        rst_n_i = 1'b0;
        step(2);
        rst_n_i = 1'b1;
    endtask : do_reset
    task automatic done(input string n);
        $display("Test %s finished, mismatches %0d", n, bad_count);
    endtask : done
    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Hang guard
    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
    // ==========================================================
    // Main sequence
    initial begin
        {rst_n_i, timer_tick_i, counter_wr_i, overflow_clear_i} = 4'h0;
        {waveform_mode_field_i, counter_wr_data_i, cmp_wr_data_i} = '0;
        {cmp_wr_i, force_match_strobe_i, pin_direction_bit_i, port_value_i} = '0;
        compare_action_field_i = '0;
        capture_value_i = 16'h0006;
        step(5);
        rst_n_i = 1'b1;
        `CHK(compare_output_state_o, 3'h0);
        `CHK(counter_value_o, 16'h0000);
        done("reset");
        port_value_i = 3'h7;
        step(1);
        `CHK(pin_oe_o, 3'h0);
        `CHK(pin_level, 3'h7);
        compare_action_field_i = 6'h03;
        pulse_force();
        `CHK(compare_output_state_o[0], 1'b1);
        `CHK(pin_oe_o[0], 1'b0);
        pin_direction_bit_i = 3'h1;
        compare_action_field_i = 6'h02;
        pulse_force();
        `CHK(pin_level[0], 1'b0);
        compare_action_field_i = 6'h00;
        step(1);
        `CHK(pin_level[0], 1'b1);
        done("pin");
        exp = 1'b0;
        foreach (tm[i]) begin
            if (tm[i] == TWMO_M_CTC_A || tm[i] == TWMO_M_CTC_CAP) begin
                waveform_mode_field_i = tm[i];
                for (int a = 0; a < 4; a++) begin
                    compare_action_field_i = 6'(a);
                    pulse_force();
                    exp = act_next(2'(a), exp);
                    `CHK(compare_output_state_o[0], exp);
                end
            end
        end
        waveform_mode_field_i = TWMO_M_FP8;
        compare_action_field_i = 6'h02;
        pulse_force();
        `CHK(compare_output_state_o[0], exp);
        done("force");
        waveform_mode_field_i = TWMO_M_NORMAL;
        cmp_wr_data_i = 16'h0005;
        cmp_wr_i = 3'h1;
        step(1);
        cmp_wr_i = 3'h0;
        foreach (acts[i]) begin
            compare_action_field_i = {4'h0, acts[i]};
            wr_cnt(16'h0003);
            `CHK(compare_output_state_o[0], exp);
            ticks(4);
            exp = act_next(acts[i], exp);
            `CHK(compare_output_state_o[0], exp);
        end
        done("match");
        wr_cnt(16'hffff);
        ticks(1);
        `CHK(counter_value_o, 16'h0000);
        `CHK(overflow_flag_o, 1'b1);
        ticks(3);
        `CHK(counter_value_o, 16'h0003);
        `CHK(overflow_flag_o, 1'b1);
        overflow_clear_i = 1'b1;
        step(1);
        overflow_clear_i = 1'b0;
        timer_tick_i = 1'b1;
        wr_cnt(16'h1234);
        timer_tick_i = 1'b0;
        `CHK(counter_value_o, 16'h1235);
        `CHK(overflow_flag_o, 1'b0);
        done("normal");
        compare_action_field_i = 6'h3f;
        foreach (tm[i]) begin
            waveform_mode_field_i = tm[i];
            if (i >= 8)
                do_reset();
            wr_cnt(ts[i]);
            ticks(2);
            `CHK(counter_value_o, te[i]);
        end
        done("tops");
        waveform_mode_field_i = TWMO_M_RSVD;
        do_reset();
        wr_cnt(16'h0042);
        ticks(4);
        pulse_force();
        `CHK(counter_value_o, 16'h0042);
        `CHK(compare_output_state_o, 3'h0);
        done("reserved");
        for (int m = 0; m < 16; m++) begin
            {waveform_mode_field_i, compare_action_field_i} = {4'(m), 6'(m * 5)};
            step(1);
            `CHK(legacy_clear_on_match_bit_o, waveform_mode_field_i[2]);
            `CHK(legacy_pulse_mode_bits_o, waveform_mode_field_i[1:0]);
            `CHK(capture_uses_top_o, 1'(m == 8 || m == 10 || m == 12 || m == 14));
        end
        done("decode");
        wrap_up();
    end
endmodule : test_timer_waveform_mode_output

// [verification/twmo_pin_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Board side of the waveform pins, a pull-up on each line
module twmo_pin_model #(
    parameter int NCH = 3
)
(
    input  wire logic [NCH-1:0] pin_out_i,
    input  wire logic [NCH-1:0] pin_oe_i,
    output logic      [NCH-1:0] pin_level_o
);
    // A released pin floats to the pull-up, not to the last driven value
    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            pin_level_o[k] = pin_oe_i[k] ? pin_out_i[k] : 1'b1;
        end
    end
endmodule : twmo_pin_model

// [verification/twmo_top_chk.sv]
`timescale 1ns/1ps
// ==========================================================
// Port-level checks of the waveform mode timer
module twmo_top_chk
    import twmo_pkg::*;
#(
    parameter int NCH = 3
)
(
    input wire logic             clk_i,
    input wire logic             rst_n_i,
    input wire logic             timer_tick_i,
    input wire logic [3:0]       waveform_mode_field_i,
    input wire logic [15:0]      counter_wr_data_i,
    input wire logic             counter_wr_i,
    input wire logic [15:0]      capture_value_i,
    input wire logic             overflow_clear_i,
    input wire logic [15:0]      cmp_wr_data_i,
    input wire logic [NCH-1:0]   cmp_wr_i,
    input wire logic [2*NCH-1:0] compare_action_field_i,
    input wire logic [NCH-1:0]   force_match_strobe_i,
    input wire logic [NCH-1:0]   pin_direction_bit_i,
    input wire logic [NCH-1:0]   port_value_i,
    input wire logic [15:0]      counter_value_o,
    input wire logic             overflow_flag_o,
    input wire logic [NCH-1:0]   compare_match_o,
    input wire logic [NCH-1:0]   compare_output_state_o,
    input wire logic [NCH-1:0]   pin_out_o,
    input wire logic [NCH-1:0]   pin_oe_o,
    input wire logic             capture_uses_top_o,
    input wire logic             legacy_clear_on_match_bit_o,
    input wire logic [1:0]       legacy_pulse_mode_bits_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [NCH-1:0] exp_pin;
    // ==========================================================
    // Expected pin source per channel
    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            exp_pin[k] = (compare_action_field_i[2*k +: 2] != TWMO_ACT_NONE) ?
                         compare_output_state_o[k] : port_value_i[k];
        end
    end
    sequence s_norm_step;
        waveform_mode_field_i == TWMO_M_NORMAL && timer_tick_i && !counter_wr_i;
    endsequence
    sequence s_force0(act);
        waveform_mode_field_i == TWMO_M_NORMAL && force_match_strobe_i[0] &&
        compare_action_field_i[1:0] == act;
    endsequence
    // ==========================================================
    // Assertions
    AST_RESET_CLEAR:
    assert property (disable iff (1'b0) !rst_n_i |=> compare_output_state_o == '0 &&
        counter_value_o == TWMO_BOTTOM) else $error("reset left state or counter set");
    AST_PIN_MUX:
    assert property (pin_out_o == exp_pin) else $error("pin source wrong");
    AST_PIN_DIR:
    assert property (pin_oe_o == pin_direction_bit_i) else $error("pin enable wrong");
    AST_ACT_ZERO:
    assert property (compare_action_field_i[1:0] == TWMO_ACT_NONE |=>
        $stable(compare_output_state_o[0])) else $error("state moved with action zero");
    AST_FORCE_SET:
    assert property (s_force0(TWMO_ACT_SET) |=> compare_output_state_o[0])
        else $error("forced set missed");
    AST_FORCE_CLR:
    assert property (s_force0(TWMO_ACT_CLEAR) |=> !compare_output_state_o[0])
        else $error("forced clear missed");
    AST_TOGGLE:
    assert property (waveform_mode_field_i == TWMO_M_NORMAL && compare_match_o[0] &&
        compare_action_field_i[1:0] == TWMO_ACT_TOGGLE && !force_match_strobe_i[0] |=>
        compare_output_state_o[0] != $past(compare_output_state_o[0]))
        else $error("toggle on match missed");
    AST_PWM_NOFORCE:
    assert property (waveform_mode_field_i == TWMO_M_FP8 && !timer_tick_i |=>
        $stable(compare_output_state_o)) else $error("state moved without tick in pwm");
    AST_NORM_WRAP:
    assert property (s_norm_step ##0 counter_value_o == TWMO_MAX |=>
        counter_value_o == TWMO_BOTTOM && overflow_flag_o) else $error("wrap wrong");
    AST_NORM_INC:
    assert property (s_norm_step ##0 counter_value_o != TWMO_MAX |=>
        counter_value_o == $past(counter_value_o) + TWMO_ONE) else $error("no increment");
    AST_OVF_STICKY:
    assert property (overflow_flag_o && !overflow_clear_i |=> overflow_flag_o)
        else $error("overflow flag dropped");
    AST_CNT_WRITE:
    assert property (counter_wr_i |=> counter_value_o == $past(counter_wr_data_i))
        else $error("counter write lost");
    AST_RSVD_HOLD:
    assert property (waveform_mode_field_i == TWMO_M_RSVD && !counter_wr_i |=>
        $stable(counter_value_o) && $stable(compare_output_state_o))
        else $error("reserved mode moved");
    AST_LEGACY:
    assert property (legacy_clear_on_match_bit_o == waveform_mode_field_i[2] &&
        legacy_pulse_mode_bits_o == waveform_mode_field_i[1:0]) else $error("legacy bits");
endmodule : twmo_top_chk
bind twmo_top twmo_top_chk #(.NCH(NCH)) twmo_top_chk_inst (.*);
